//--- logic/edit_memory_sequencer.sv
// edit memory sequencer: places keyboard characters into core memory
// assumes memory data valid during phase two; AXI4-Lite master obeys protocol
module edit_memory_sequencer
(
   input  wire logic                                  clock,
   input  wire logic                                  rst_n,
   input  wire edit_seq_pkg::key_in_t                 key_in,
   input  wire logic                                  prefix_position_bit,
   input  wire logic                                  cursor_over_end,
   input  wire logic [edit_seq_pkg::CHAR_W-1:0]       mem_rdata,
   output      edit_seq_pkg::key_out_t                key_out,
   output      edit_seq_pkg::mem_out_t                mem_out,
   input  wire logic [edit_seq_pkg::AXI_AW-1:0]       awaddr,
   input  wire logic                                  awvalid,
   output      logic                                  awready,
   input  wire logic [31:0]                           wdata,
   input  wire logic [3:0]                            wstrb,
   input  wire logic                                  wvalid,
   output      logic                                  wready,
   output      logic [1:0]                            bresp,
   output      logic                                  bvalid,
   input  wire logic                                  bready,
   input  wire logic [edit_seq_pkg::AXI_AW-1:0]       araddr,
   input  wire logic                                  arvalid,
   output      logic                                  arready,
   output      logic [31:0]                           rdata,
   output      logic [1:0]                            rresp,
   output      logic                                  rvalid,
   input  wire logic                                  rready
);

   //==========================================================
   // state record
   typedef struct packed {
      edit_seq_pkg::phase_t                 phase;        // memory timing
      logic [edit_seq_pkg::ADDR_W-1:0]      cursor;       // cursor address
      logic [edit_seq_pkg::ADDR_W-1:0]      memaddr;      // memory address
      logic [edit_seq_pkg::CHAR_W-1:0]      key_char;     // keyboard storage
      logic [edit_seq_pkg::CHAR_W-1:0]      display;      // display register
      logic [edit_seq_pkg::CHAR_W-1:0]      memory_input_register;          // memory input reg
      logic                                 replace_one;  // replace_one_flag
      logic                                 replace_two;  // replace_two_flag
      logic                                 second_cycle; // second_cycle_flag
      logic                                 insert_one;   // insert_one_flag
      logic                                 push;         // push_in_progress
      logic                                 one_left;     // last push cycle
      logic                                 pull_one;     // pull-by-1 overwrite
      logic                                 pull_move;    // pull shifting
      logic                                 pull_two;     // shift by two
      logic                                 delete_pend;  // delete requested
      edit_seq_pkg::key_out_t               kout;         // keyboard outputs
      edit_seq_pkg::mem_out_t               mout;         // memory outputs
      logic                                 aw_got;       // address held
      logic [edit_seq_pkg::AXI_AW-1:0]      aw_addr;      // held address
      logic                                 w_got;        // data held
      logic [31:0]                          w_data;       // held data
      logic [3:0]                           w_strb;       // held strobes
      logic                                 awready;      // bus outputs
      logic                                 wready;
      logic                                 bvalid;
      logic [1:0]                           bresp;
      logic                                 arready;
      logic                                 rvalid;
      logic [31:0]                          rdata;
      logic [1:0]                           rresp;
   } state_t;

   state_t                              s_reg;    // registered state
   state_t                              s_next;   // next state
   logic                                req;      // edit_memory_request
   logic                                cyc_on;   // edit cycle follows
   logic [edit_seq_pkg::ADDR_W-1:0]     shift;    // pull distance
   logic [edit_seq_pkg::ADDR_W-1:0]     addr_sel; // chosen address
   logic [31:0]                         status;   // status word

   //==========================================================
   // next-state logic
   always_comb
   begin
      s_next = s_reg;
      s_next.kout.release_p  = 1'b0;
      s_next.kout.complete_p = 1'b0;

      //==========================================================
      // keyboard strobe and delete start, only between sequences
      if (s_reg.phase == edit_seq_pkg::PH_IDLE && !s_reg.kout.busy)
      begin
         if (key_in.avail && key_in.get_done)
         begin
            s_next.key_char       = key_in.chars;
            s_next.kout.release_p = 1'b1;
            s_next.kout.busy      = 1'b1;
            if (key_in.two_slot)
            begin
               // two-slot key over prefix: equal replace
               if (prefix_position_bit)
               begin
                  s_next.replace_two = 1'b1;
               end
               else
               begin
                  // unsupported placement: drop, free keyboards
                  s_next.kout.busy       = 1'b0;
                  s_next.kout.complete_p = 1'b1;
               end
            end
            else if (cursor_over_end)
            begin
               s_next.insert_one = 1'b1;
            end
            else if (prefix_position_bit)
            begin
               s_next.pull_one = 1'b1;
            end
            else
            begin
               s_next.replace_one = 1'b1;
            end
         end
         else if (s_reg.delete_pend)
         begin
            // delete the two-slot character under the cursor
            s_next.delete_pend = 1'b0;
            s_next.kout.busy   = 1'b1;
            s_next.pull_move   = 1'b1;
            s_next.pull_two    = 1'b1;
            s_next.memaddr     = s_reg.cursor;
         end
      end

      //==========================================================
      // per-phase actions
      case (s_reg.phase)
         edit_seq_pkg::PH_ONE:
         begin
            // key or prefix into display
            if (s_reg.replace_one || s_reg.insert_one || s_reg.pull_one)
            begin
               s_next.display = s_reg.key_char;
            end
            if (s_reg.replace_two)
            begin
               s_next.display = s_reg.second_cycle ? s_reg.key_char
                                                   : edit_seq_pkg::PREFIX_CODE;
            end
            if (s_reg.insert_one)
            begin
               s_next.memaddr = edit_seq_pkg::ADDR_RESET;
            end
         end
         edit_seq_pkg::PH_TWO:
         begin
            // read data lands in memory input register
            s_next.memory_input_register = mem_rdata;
            if (s_reg.insert_one)
            begin
               s_next.memaddr = s_reg.cursor;
            end
            if (s_reg.pull_move)
            begin
               s_next.display = mem_rdata;
            end
         end
         edit_seq_pkg::PH_FOUR:
         begin
            if (s_reg.replace_one)
            begin
               s_next.cursor          = s_reg.cursor + edit_seq_pkg::ADDR_ONE;
               s_next.replace_one     = 1'b0;
               s_next.kout.complete_p = 1'b1;
               s_next.kout.busy       = 1'b0;
            end
            if (s_reg.replace_two)
            begin
               s_next.cursor = s_reg.cursor + edit_seq_pkg::ADDR_ONE;
               if (!s_reg.second_cycle)
               begin
                  s_next.second_cycle = 1'b1;
               end
               else
               begin
                  // second of two cycles
                  s_next.second_cycle    = 1'b0;
                  s_next.replace_two     = 1'b0;
                  s_next.kout.complete_p = 1'b1;
                  s_next.kout.busy       = 1'b0;
               end
            end
            if (s_reg.insert_one)
            begin
               s_next.insert_one = 1'b0;
               s_next.memaddr    = s_reg.memaddr + edit_seq_pkg::ADDR_ONE;
               s_next.push       = 1'b1;
               s_next.one_left   = 1'b1;
            end
            else if (s_reg.push)
            begin
               s_next.push            = 1'b0;
               s_next.one_left        = 1'b0;
               s_next.cursor          = s_reg.cursor + edit_seq_pkg::ADDR_ONE;
               s_next.kout.complete_p = 1'b1;
               s_next.kout.busy       = 1'b0;
            end
            if (s_reg.pull_one)
            begin
               // overwrite done; shift from next slot on
               s_next.pull_one  = 1'b0;
               s_next.pull_move = 1'b1;
               s_next.pull_two  = 1'b0;
               s_next.cursor    = s_reg.cursor + edit_seq_pkg::ADDR_ONE;
               s_next.memaddr   = s_reg.cursor + edit_seq_pkg::ADDR_ONE;
            end
            else if (s_reg.pull_move)
            begin
               s_next.memaddr = s_reg.memaddr + edit_seq_pkg::ADDR_ONE;
               // end marker moved: sequence over
               if (s_reg.display == edit_seq_pkg::END_MARKER)
               begin
                  s_next.pull_move       = 1'b0;
                  s_next.pull_two        = 1'b0;
                  s_next.kout.complete_p = 1'b1;
                  s_next.kout.busy       = 1'b0;
               end
            end
         end
         edit_seq_pkg::PH_FIVE:
         begin
            // end marker follows into display
            if (s_reg.push && s_reg.one_left)
            begin
               s_next.display = s_reg.memory_input_register;
            end
         end
         default:
         begin
         end
      endcase

      //==========================================================
      // memory timing sequence
      req    = s_next.replace_one | s_next.replace_two | s_next.insert_one
             | s_next.push | s_next.pull_one | s_next.pull_move;
      cyc_on = req;
      case (s_reg.phase)
         edit_seq_pkg::PH_IDLE:  s_next.phase = cyc_on ? edit_seq_pkg::PH_ONE
                                                       : edit_seq_pkg::PH_IDLE;
         edit_seq_pkg::PH_ONE:   s_next.phase = edit_seq_pkg::PH_TWO;
         edit_seq_pkg::PH_TWO:   s_next.phase = edit_seq_pkg::PH_THREE;
         edit_seq_pkg::PH_THREE: s_next.phase = edit_seq_pkg::PH_FOUR;
         edit_seq_pkg::PH_FOUR:  s_next.phase = cyc_on ? edit_seq_pkg::PH_FIVE
                                                       : edit_seq_pkg::PH_IDLE;
         default:                s_next.phase = edit_seq_pkg::PH_ONE;
      endcase

      //==========================================================
      // memory port outputs for the coming phase
      shift = s_next.pull_two ? edit_seq_pkg::ADDR_TWO : edit_seq_pkg::ADDR_ONE;
      if (s_next.pull_move)
      begin
         // read ahead by shift, write back at memaddr
         addr_sel = (s_next.phase == edit_seq_pkg::PH_ONE || s_next.phase == edit_seq_pkg::PH_TWO)
                  ? s_next.memaddr + shift : s_next.memaddr;
      end
      else if (s_next.push)
      begin
         addr_sel = s_next.memaddr;
      end
      else
      begin
         addr_sel = s_next.cursor;
      end
      s_next.mout.addr     = addr_sel;
      s_next.mout.cur_mode = !s_next.pull_move && !s_next.push;
      s_next.mout.rd       = s_next.phase == edit_seq_pkg::PH_ONE
                           || s_next.phase == edit_seq_pkg::PH_TWO;
      s_next.mout.wr       = s_next.phase == edit_seq_pkg::PH_THREE
                           || s_next.phase == edit_seq_pkg::PH_FOUR;
      s_next.mout.inhibit  = s_next.phase != edit_seq_pkg::PH_IDLE;
      s_next.mout.wdata    = s_next.display;

      //==========================================================
      // bus write channels
      if (s_reg.awready && awvalid)
      begin
         s_next.aw_got  = 1'b1;
         s_next.aw_addr = awaddr;
      end
      if (s_reg.wready && wvalid)
      begin
         s_next.w_got  = 1'b1;
         s_next.w_data = wdata;
         s_next.w_strb = wstrb;
      end
      if (s_reg.bvalid && bready)
      begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = edit_seq_pkg::RESP_OKAY;
         if (s_reg.aw_addr == edit_seq_pkg::OFF_CONTROL)
         begin
            // delete request, held until sequencer is free
            if (s_reg.w_strb[0] && s_reg.w_data[edit_seq_pkg::CTRL_DELETE])
            begin
               s_next.delete_pend = 1'b1;
            end
         end
         else if (s_reg.aw_addr == edit_seq_pkg::OFF_CURSOR)
         begin
            // cursor writes only take effect while no sequence runs
            if (s_reg.phase == edit_seq_pkg::PH_IDLE && !s_reg.kout.busy && !s_next.kout.busy)
            begin
               if (s_reg.w_strb[0])
               begin
                  s_next.cursor[7:0] = s_reg.w_data[7:0];
               end
               if (s_reg.w_strb[1])
               begin
                  s_next.cursor[9:8] = s_reg.w_data[9:8];
               end
            end
         end
         else if (s_reg.aw_addr == edit_seq_pkg::OFF_STATUS || s_reg.aw_addr == edit_seq_pkg::OFF_MEMADDR)
         begin
            // read-only: write ignored
         end
         else
         begin
            s_next.bresp = edit_seq_pkg::RESP_SLVERR;
         end
      end
      s_next.awready = !s_next.aw_got && !s_next.bvalid;
      s_next.wready  = !s_next.w_got && !s_next.bvalid;

      //==========================================================
      // bus read channels
      status = {23'h000000, s_reg.delete_pend, s_reg.phase != edit_seq_pkg::PH_IDLE,
                s_reg.pull_one | s_reg.pull_move, s_reg.push, s_reg.insert_one,
                s_reg.second_cycle, s_reg.replace_two, s_reg.replace_one, s_reg.kout.busy};
      if (s_reg.rvalid && rready)
      begin
         s_next.rvalid = 1'b0;
      end
      if (s_reg.arready && arvalid)
      begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = edit_seq_pkg::RESP_OKAY;
         s_next.rdata  = 32'h00000000;
         if (araddr == edit_seq_pkg::OFF_CONTROL)
         begin
            s_next.rdata[edit_seq_pkg::CTRL_DELETE] = s_reg.delete_pend;
         end
         else if (araddr == edit_seq_pkg::OFF_CURSOR)
         begin
            s_next.rdata[9:0] = s_reg.cursor;
         end
         else if (araddr == edit_seq_pkg::OFF_STATUS)
         begin
            s_next.rdata = status;
         end
         else if (araddr == edit_seq_pkg::OFF_MEMADDR)
         begin
            s_next.rdata[9:0] = s_reg.memaddr;
         end
         else
         begin
            s_next.rresp = edit_seq_pkg::RESP_SLVERR;
         end
      end
      s_next.arready = !s_next.rvalid;
   end

   //==========================================================
   // state register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   //==========================================================
   // outputs straight from the state register
   assign key_out = s_reg.kout;
   assign mem_out = s_reg.mout;
   assign awready = s_reg.awready;
   assign wready  = s_reg.wready;
   assign bvalid  = s_reg.bvalid;
   assign bresp   = s_reg.bresp;
   assign arready = s_reg.arready;
   assign rvalid  = s_reg.rvalid;
   assign rdata   = s_reg.rdata;
   assign rresp   = s_reg.rresp;

endmodule : edit_memory_sequencer

//--- logic/edit_seq_pkg.sv
// constants, types and carriers for the edit memory sequencer
// assumes one 40 MHz clock, asynchronous active-low reset, AXI4-Lite host
package edit_seq_pkg;

   //==========================================================
   // widths and character codes
   localparam int                ADDR_W      = 10;
   localparam int                CHAR_W      = 6;
   localparam int                AXI_AW      = 8;
   localparam logic [CHAR_W-1:0] PREFIX_CODE = 6'h3E;  // plain default
   localparam logic [CHAR_W-1:0] END_MARKER  = 6'h3F;  // plain default
   localparam logic [ADDR_W-1:0] ADDR_ONE    = 10'h001;
   localparam logic [ADDR_W-1:0] ADDR_TWO    = 10'h002;
   localparam logic [ADDR_W-1:0] ADDR_RESET  = 10'h000;

   //==========================================================
   // register map
   localparam logic [AXI_AW-1:0] OFF_CONTROL = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_CURSOR  = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_STATUS  = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_MEMADDR = 8'h0C;
   localparam int                CTRL_DELETE = 0;
   localparam logic [1:0]        RESP_OKAY   = 2'h0;
   localparam logic [1:0]        RESP_SLVERR = 2'h2;

   //==========================================================
   // memory timing phases
   typedef enum logic [2:0] {PH_IDLE, PH_ONE, PH_TWO, PH_THREE, PH_FOUR, PH_FIVE} phase_t;

   // keyboard side inputs
   typedef struct packed {
      logic              avail;     // key_char_available
      logic              get_done;  // get sequence finished
      logic              two_slot;  // two_slot_char_flag
      logic [CHAR_W-1:0] chars;     // decoded_input_lines
   } key_in_t;

   // keyboard side outputs
   typedef struct packed {
      logic release_p;  // key_load_release
      logic complete_p; // key_load_complete
      logic busy;       // keyboard_busy_flag
   } key_out_t;

   // core memory side outputs
   typedef struct packed {
      logic [ADDR_W-1:0] addr;     // location addressed
      logic              rd;       // read phases
      logic              wr;       // write phases
      logic              inhibit;  // display_to_inhibit_gate
      logic              cur_mode; // cursor_addressing_allow
      logic [CHAR_W-1:0] wdata;    // display register
   } mem_out_t;

endpackage : edit_seq_pkg

//--- verification/core_mem_model.sv
// behavioural core memory on the far side of the sequencer
// assumes address, strobes and data registered by the sequencer
module core_mem_model
(
   input wire logic                            clock,
   input wire edit_seq_pkg::mem_out_t          mem_out,
   output     logic [edit_seq_pkg::CHAR_W-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [edit_seq_pkg::CHAR_W-1:0] cells [0:1023]; // six-bit core words
   // write phases store the inhibit lines
   always @(posedge clock)
   begin
      if (mem_out.wr)
         cells[mem_out.addr] <= mem_out.wdata;
   end
   // cell while reading, inverted value otherwise
   assign mem_rdata = mem_out.rd ? cells[mem_out.addr] : ~cells[mem_out.addr];
endmodule : core_mem_model

//--- verification/edit_seq_monitor.sv
// checker for the keyboard and core memory ports of the sequencer
// assumes it is bound onto edit_memory_sequencer, one clock domain
module edit_seq_monitor
(
   input wire logic                   clock,
   input wire logic                   rst_n,
   input wire edit_seq_pkg::key_in_t  key_in,
   input wire edit_seq_pkg::key_out_t key_out,
   input wire edit_seq_pkg::mem_out_t mem_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   //==========================================
   // keyboard handshake
   property p_take; key_in.avail && key_in.get_done && !key_out.busy && !mem_out.inhibit
      |=> key_out.release_p && key_out.busy; endproperty
   a_take: assert property (p_take) else $error("key not taken");
   property p_wait_get; !key_in.get_done && !key_out.busy |=> !key_out.release_p; endproperty
   a_wait_get: assert property (p_wait_get) else $error("strobe before get done");
   property p_pulse; key_out.release_p |=> !key_out.release_p; endproperty
   a_pulse: assert property (p_pulse) else $error("release too long");
   property p_fall; $fell(key_out.busy) |-> key_out.complete_p; endproperty
   a_fall: assert property (p_fall) else $error("busy fell alone");
   property p_done; key_out.complete_p |-> !key_out.busy && !mem_out.inhibit; endproperty
   a_done: assert property (p_done) else $error("cycle runs on");
   //==========================================
   // memory cycle phases
   property p_steps; $rose(mem_out.rd) |=> mem_out.rd ##1 mem_out.wr [*2] ##1 !mem_out.wr; endproperty
   a_steps: assert property (p_steps) else $error("phase order");
   property p_gate; mem_out.rd || mem_out.wr |-> mem_out.inhibit; endproperty
   a_gate: assert property (p_gate) else $error("inhibit gate low");
   property p_pair; $rose(mem_out.wr) && mem_out.cur_mode && mem_out.wdata == edit_seq_pkg::PREFIX_CODE
      |-> ##3 mem_out.rd && mem_out.addr == $past(mem_out.addr, 3) + edit_seq_pkg::ADDR_ONE; endproperty
   a_pair: assert property (p_pair) else $error("second cycle missing");
endmodule : edit_seq_monitor

bind edit_memory_sequencer edit_seq_monitor u_mon (.clock, .rst_n, .key_in, .key_out, .mem_out);

//--- verification/tb_top.sv
// self-checking bench for the edit memory sequencer
// assumes the core model and the bound checker are compiled first
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_n, prefix_position_bit, cursor_over_end, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;            // d holds the last read word
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;            // r holds the last response
   logic [5:0]  mem_rdata;
   edit_seq_pkg::key_in_t  key_in;
   edit_seq_pkg::key_out_t key_out;
   edit_seq_pkg::mem_out_t mem_out;
   int error_cnt, n_compared;
   edit_memory_sequencer uut (.clock, .rst_n, .key_in, .prefix_position_bit, .cursor_over_end, .mem_rdata,
      .key_out, .mem_out, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   core_mem_model u_mem (.clock, .mem_out, .mem_rdata);
   //==========================================
   // bus and keyboard tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hF, 3'h7};
      do
      begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do
      begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      {d, r} = {rdata, rresp};
      rready <= 1'b0;
   endtask : rd
   // keyboard presents its character at its frame time
   task automatic key(input logic ts, pp, ce, input logic [5:0] c);
      @(posedge clock);
      // character offered before its get sequence is over: must wait
      {key_in, prefix_position_bit, cursor_over_end} <= {2'h2, ts, c, pp, ce};
      repeat (3) @(posedge clock);
      `CHK("early strobe", 1'b0, key_out.release_p)
      key_in.get_done <= 1'b1;
      do @(posedge clock); while (!key_out.release_p);
      key_in.avail <= 1'b0;
      do @(posedge clock); while (!key_out.complete_p);
   endtask : key
   task automatic cur(input logic [9:0] e);
      rd(edit_seq_pkg::OFF_CURSOR);
      `CHK("cursor", e, d[9:0])
   endtask : cur
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   //==========================================
   // clock, watchdog and test sequence
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      results();
   end
   initial
   begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, prefix_position_bit, cursor_over_end} = '0;
      {awaddr, araddr, wdata, wstrb, key_in, error_cnt, n_compared} = '0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      cur(10'h000);
      rd(8'h10);
      `CHK("unmapped", edit_seq_pkg::RESP_SLVERR, r)
      wr(edit_seq_pkg::OFF_CURSOR, 32'h00000005);
      `CHK("write resp", edit_seq_pkg::RESP_OKAY, r)
      key(1'b0, 1'b0, 1'b0, 6'h11);
      `CHK("one slot", 6'h11, u_mem.cells[5])
      cur(10'h006);
      key(1'b1, 1'b1, 1'b0, 6'h22);
      `CHK("prefix", edit_seq_pkg::PREFIX_CODE, u_mem.cells[6])
      `CHK("two slot", 6'h22, u_mem.cells[7])
      cur(10'h008);
      u_mem.cells[8] = edit_seq_pkg::END_MARKER;
      key(1'b0, 1'b0, 1'b1, 6'h33);
      `CHK("insert", 6'h33, u_mem.cells[8])
      `CHK("pushed end", edit_seq_pkg::END_MARKER, u_mem.cells[9])
      cur(10'h009);
      rd(edit_seq_pkg::OFF_MEMADDR);
      `CHK("memaddr", 10'h009, d[9:0])
      {u_mem.cells[2], u_mem.cells[3], u_mem.cells[4], u_mem.cells[5]} = {6'h3E, 6'h01, 6'h0A, 6'h3F};
      wr(edit_seq_pkg::OFF_CURSOR, 32'h00000002);
      key(1'b0, 1'b1, 1'b0, 6'h15);
      `CHK("pull one", {6'h15, 6'h0A, 6'h3F}, {u_mem.cells[2], u_mem.cells[3], u_mem.cells[4]})
      {u_mem.cells[10], u_mem.cells[11], u_mem.cells[12], u_mem.cells[13]} = {6'h3E, 6'h02, 6'h0B, 6'h3F};
      wr(edit_seq_pkg::OFF_CURSOR, 32'h0000000A);
      wr(edit_seq_pkg::OFF_CONTROL, 32'h00000001);
      repeat (40)
      begin
         rd(edit_seq_pkg::OFF_STATUS);
         if (d[8:7] === 2'b00) break;
      end
      `CHK("pull two", {6'h0B, 6'h3F}, {u_mem.cells[10], u_mem.cells[11]})
      results();
   end
endmodule : tb_top
